// >>> verilog/psc_consts.vh
// Constants for the power saving control block: offsets, fields, resets, timing
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH
// Register word offsets (byte addresses)
`define PSC_ADDR_WAKECTL 4'h0
`define PSC_ADDR_RESETCTL 4'h4
`define PSC_ADDR_CLOCK_DIVIDER_REG 4'h8
`define PSC_ADDR_STATUS 4'hc
// Wake pin control register fields
`define PSC_WAKE_EN_BIT 15
`define PSC_WAKE_SIDL_BIT 13
`define PSC_WAKE_SINK_BIT 8
`define PSC_WAKECTL_MASK 16'ha100
// Reset control register fields
`define PSC_LVR_EN_BIT 12
`define PSC_SLEEP_POWER_MODE_SELECT_BIT 8
`define PSC_RESETCTL_MASK 16'h1100
// Clock divider register fields
`define PSC_ROI_BIT 15
`define PSC_DOZE_HI 14
`define PSC_DOZE_LO 12
`define PSC_CPU_SLOWDOWN_ENABLE_BIT 11
`define PSC_CLOCK_DIVIDER_REG_MASK 16'hf800
// Status register: [0] wake irq flag, [1] wake event, [8] mask bit for [0], [9] for [1]
`define PSC_ST_WAKE_BIT 0
`define PSC_ST_RESUME_BIT 1
`define PSC_MASK_LO 8
// Reset values
`define PSC_RESET_WORD 16'h0000
// Wake-up delays in ns for each sleep mode
`define PSC_WAKE_FAST_NS 100
`define PSC_WAKE_STBY_NS 1000
`define PSC_WAKE_LV_NS 3000
`define PSC_WAKE_DEEP_NS 10000
`define PSC_CLK_NS 10
// Power modes
`define PSC_MODE_RUN 3'h0
`define PSC_MODE_FAST 3'h1
`define PSC_MODE_STBY 3'h2
`define PSC_MODE_LV 3'h3
`define PSC_MODE_DEEP 3'h4
`endif

// >>> verilog/psc_doze_div.v
// CPU clock-enable divider for reduced-speed mode
`timescale 1ns/1ns
`include "psc_consts.vh"
module psc_doze_div #(
    parameter WIDTH = 7
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    input wire clkEn,
    // Control
    input wire slowActive,
    input wire [2:0] ratioCode,
    // Output
    output reg cpuTick
);
    reg [WIDTH-1:0] count;
    wire [WIDTH-1:0] limit;

    // Terminal count is two to the power n, minus one
    assign limit = (({{(WIDTH-1){1'b0}}, 1'b1}) << ratioCode) - {{(WIDTH-1){1'b0}}, 1'b1};

    // Counter rolls on the peripheral clock so both domains stay aligned
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            count <= {WIDTH{1'b0}};
            cpuTick <= 1'b0;
        end else if (clkEn) begin
            if (!slowActive || count >= limit) begin
                count <= {WIDTH{1'b0}};
                cpuTick <= 1'b1;
            end else begin
                count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
                cpuTick <= 1'b0;
            end
        end
    end
endmodule

// >>> verilog/psc_power_ctl.v
// Power saving control: wake pin unit, sleep regulator mode, CPU slowdown
`timescale 1ns/1ns
`include "psc_consts.vh"
// Notes on behaviour
// - Wake control bit 15 enables the wake-up unit.
// - Bit 13 halts the wake-up unit during Idle when set.
// - Bit 8 switches on the capacitor discharge current sink.
// - Unimplemented wake control bits read zero and ignore writes.
// - Low pin during Sleep wakes device and sets wake irq flag.
// - Power-mode-sleep set gives fast wake-up, main regulator full.
// - Mode bit clear, low-volt off: main regulator standby in Sleep.
// - Fuse clear, low-volt on, mode clear: only low-volt regulator.
// - Fuse set keeps low-volt regulator off, enable ignored.
// - Run mode: main regulator full, low-volt unused.
// - Standby wakes slower than fast; low-voltage slower still.
// - Deep Sleep shuts both regulators, longest wake-up.
// - Slowdown enable reduces CPU clock only, peripherals unchanged.
// - Three-bit ratio selects 1:1 to 1:128, default 1:1.
// - Return-on-interrupt set makes interrupts restore full speed.
// - CPU and peripheral clocks stay synchronous while slowed.
module psc_power_ctl #(
    parameter DIV_WIDTH = 7,
    parameter DEEP_WAKE_CYCLES = (`PSC_WAKE_DEEP_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS
) (
    // Clock, reset, enable
    input wire sys_clk,
    input wire rst_n,
    input wire clkEn,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Device state
    input wire sleepReq,
    input wire deepSleepReq,
    input wire idleMode,
    input wire cpuIrq,
    input wire low_volt_reg_fuse,
    // Wake sense pin (digital level, low below threshold)
    input wire wake_sense_pin,
    // Outputs
    output reg capacitorSinkOn,
    output reg wake_pin_irq_flag,
    output reg inSleep,
    output reg mainRegFull,
    output reg mainRegStandby,
    output reg lowVoltRegOn,
    output reg coreFromLowVolt,
    output reg cpuClkEn,
    output reg irqOut
);
    // ------------------------------------------------------------
    // Parameters and state
    // ------------------------------------------------------------
    localparam ST_RUN = 3'b001;
    localparam ST_SLEEP = 3'b010;
    localparam ST_WAKE = 3'b100;
    // Wake-up waits in cycles, rounded up so a slower clock never shortens them
    localparam integer FAST_CYC = (`PSC_WAKE_FAST_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS;
    localparam integer STBY_CYC = (`PSC_WAKE_STBY_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS;
    localparam integer LV_CYC = (`PSC_WAKE_LV_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS;

    // Control words; only their writable bits can ever become set
    reg [15:0] wakeCtl;
    reg [15:0] resetCtl;
    reg [15:0] clock_divider_reg;
    reg [1:0] status;
    reg [1:0] irqMask;
    reg [2:0] state;
    reg [2:0] sleepMode;
    reg [15:0] wakeCount;
    reg slowCancelled;
    reg [15:0] next_word;
    reg [31:0] next_rdata;
    reg [2:0] next_mode;
    wire cpuTick;
    wire slowActive;
    wire busReq;
    wire unitActive;
    wire pinWake;
    wire rdStatus;
    wire [1:0] events;

    // Merge write data into a 16-bit register under byte enables
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] wdat;
        input [1:0] sel;
        input [15:0] mask;
        begin
            merge16[7:0] = sel[0] ? wdat[7:0] : old[7:0];
            merge16[15:8] = sel[1] ? wdat[15:8] : old[15:8];
            merge16 = merge16 & mask;
        end
    endfunction

    // Wake-up delay for a given sleep mode
    function [15:0] wakeDelay;
        input [2:0] mode;
        begin
            // Run and deep share the default, so an odd mode waits longest
            case (mode)
                `PSC_MODE_FAST: wakeDelay = FAST_CYC[15:0];
                `PSC_MODE_STBY: wakeDelay = STBY_CYC[15:0];
                `PSC_MODE_LV: wakeDelay = LV_CYC[15:0];
                default: wakeDelay = DEEP_WAKE_CYCLES[15:0];
            endcase
        end
    endfunction

    // True while sleeping in the given regulator mode
    function sleepingIn;
        input [2:0] st;
        input [2:0] mode;
        input [2:0] want;
        begin
            sleepingIn = (st == ST_SLEEP) && (mode == want);
        end
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Ack is a one-cycle pulse; it drops in the cycle after it rose
    // Without the ack term a strobe still held would be taken twice
    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rdStatus = busReq && !wb_we_i && (wb_adr_i == `PSC_ADDR_STATUS);

    // Wake unit runs only when enabled and not parked by Idle
    // enable and idle stop
    assign unitActive = wakeCtl[`PSC_WAKE_EN_BIT] &&
        !(idleMode && wakeCtl[`PSC_WAKE_SIDL_BIT]);
    assign pinWake = unitActive && (state == ST_SLEEP) && !wake_sense_pin &&
        (sleepMode != `PSC_MODE_DEEP);
    // Event 0 is the pin wake, event 1 the end of the wake-up wait
    assign events = {(state == ST_WAKE) && (wakeCount == 16'h0000), pinWake};

    // interrupt cancels slowdown when return-on-irq is set
    assign slowActive = clock_divider_reg[`PSC_CPU_SLOWDOWN_ENABLE_BIT] && !slowCancelled;

    // Regulator mode chosen from fuse, low-volt enable and mode bit
    always @* begin
        next_mode = `PSC_MODE_STBY;
        if (deepSleepReq) begin
            next_mode = `PSC_MODE_DEEP;
        end else if (resetCtl[`PSC_SLEEP_POWER_MODE_SELECT_BIT]) begin
            next_mode = `PSC_MODE_FAST;
        end else if (!low_volt_reg_fuse && resetCtl[`PSC_LVR_EN_BIT]) begin
            // low-voltage sleep only with fuse clear
            next_mode = `PSC_MODE_LV;
        end else begin
            next_mode = `PSC_MODE_STBY;
        end
    end

    // Read data mux; unmapped addresses read zero
    // Mask bits share the status word: the bus reaches only four words
    always @* begin
        next_rdata = 32'h00000000;
        case (wb_adr_i)
            `PSC_ADDR_WAKECTL: next_rdata = {16'h0000, wakeCtl & `PSC_WAKECTL_MASK};
            `PSC_ADDR_RESETCTL: next_rdata = {16'h0000, resetCtl};
            `PSC_ADDR_CLOCK_DIVIDER_REG: next_rdata = {16'h0000, clock_divider_reg};
            `PSC_ADDR_STATUS: next_rdata = {22'h000000, irqMask, 6'h00, status};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Selected write word for the addressed register
    always @* begin
        next_word = 16'h0000;
        case (wb_adr_i)
            `PSC_ADDR_WAKECTL: next_word = merge16(wakeCtl, wb_dat_i[15:0], wb_sel_i[1:0],
                `PSC_WAKECTL_MASK);
            `PSC_ADDR_RESETCTL: next_word = merge16(resetCtl, wb_dat_i[15:0], wb_sel_i[1:0],
                `PSC_RESETCTL_MASK);
            `PSC_ADDR_CLOCK_DIVIDER_REG: next_word = merge16(clock_divider_reg, wb_dat_i[15:0], wb_sel_i[1:0],
                `PSC_CLOCK_DIVIDER_REG_MASK);
            default: next_word = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Registers and bus answer
    // ------------------------------------------------------------
    // Every access is answered one cycle after it is seen
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            wakeCtl <= `PSC_RESET_WORD;
            resetCtl <= `PSC_RESET_WORD;
            clock_divider_reg <= `PSC_RESET_WORD;
            irqMask <= 2'b00;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (clkEn) begin
            wb_ack_o <= busReq;
            if (busReq && !wb_we_i) begin
                wb_dat_o <= next_rdata;
            end
            // Unmapped writes and read-only status bits are dropped
            if (busReq && wb_we_i) begin
                case (wb_adr_i)
                    `PSC_ADDR_WAKECTL: wakeCtl <= next_word;
                    `PSC_ADDR_RESETCTL: resetCtl <= next_word;
                    `PSC_ADDR_CLOCK_DIVIDER_REG: clock_divider_reg <= next_word;
                    `PSC_ADDR_STATUS: begin
                        if (wb_sel_i[1]) begin
                            irqMask <= wb_dat_i[`PSC_MASK_LO+1:`PSC_MASK_LO];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Sticky events; a status read clears them but a new event wins
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            status <= 2'b00;
            irqOut <= 1'b0;
        end else if (clkEn) begin
            status <= (rdStatus ? 2'b00 : status) | events;
            irqOut <= |(((rdStatus ? 2'b00 : status) | events) & irqMask);
        end
    end

    // ------------------------------------------------------------
    // Sleep sequencing and regulator control
    // ------------------------------------------------------------
    // Wait state counts the mode's wake-up time before returning to run
    // Deep sleep ignores the pin: only the request falling ends it
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= ST_RUN;
            sleepMode <= `PSC_MODE_RUN;
            wakeCount <= 16'h0000;
        end else if (clkEn) begin
            case (state)
                ST_RUN: begin
                    if (sleepReq || deepSleepReq) begin
                        state <= ST_SLEEP;
                        sleepMode <= next_mode;
                    end
                end
                ST_SLEEP: begin
                    if (pinWake || (sleepMode == `PSC_MODE_DEEP && !deepSleepReq)) begin
                        state <= ST_WAKE;
                        wakeCount <= wakeDelay(sleepMode);
                    end
                end
                ST_WAKE: begin
                    if (wakeCount == 16'h0000) begin
                        state <= ST_RUN;
                        sleepMode <= `PSC_MODE_RUN;
                    end else begin
                        wakeCount <= wakeCount - 16'h0001;
                    end
                end
                default: begin
                    state <= ST_RUN;
                    sleepMode <= `PSC_MODE_RUN;
                end
            endcase
        end
    end

    // Regulator outputs follow the held sleep mode
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            inSleep <= 1'b0;
            mainRegFull <= 1'b1;
            mainRegStandby <= 1'b0;
            lowVoltRegOn <= 1'b0;
            coreFromLowVolt <= 1'b0;
            capacitorSinkOn <= 1'b0;
            wake_pin_irq_flag <= 1'b0;
        end else if (clkEn) begin
            inSleep <= (state == ST_SLEEP);
            // run and fast mode keep main regulator full
            mainRegFull <= (state != ST_SLEEP) || (sleepMode == `PSC_MODE_FAST);
            mainRegStandby <= sleepingIn(state, sleepMode, `PSC_MODE_STBY);
            // low-volt regulator only in low-voltage sleep
            // The fuse is rechecked here so a late fuse change still wins
            lowVoltRegOn <= sleepingIn(state, sleepMode, `PSC_MODE_LV) && !low_volt_reg_fuse;
            coreFromLowVolt <= sleepingIn(state, sleepMode, `PSC_MODE_LV) && !low_volt_reg_fuse;
            // sink follows its bit while the unit runs
            capacitorSinkOn <= unitActive && wakeCtl[`PSC_WAKE_SINK_BIT];
            // flag set on wake, status read clears it; set wins
            wake_pin_irq_flag <= pinWake || (wake_pin_irq_flag && !rdStatus);
        end
    end

    // ------------------------------------------------------------
    // Reduced CPU speed
    // ------------------------------------------------------------
    // Cancel latch clears when slowdown is rewritten off
    // Limitation: after a cancel the CPU stays at full speed until the enable is cleared
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            slowCancelled <= 1'b0;
            cpuClkEn <= 1'b0;
        end else if (clkEn) begin
            if (!clock_divider_reg[`PSC_CPU_SLOWDOWN_ENABLE_BIT]) begin
                slowCancelled <= 1'b0;
            end else if (cpuIrq && clock_divider_reg[`PSC_ROI_BIT]) begin
                slowCancelled <= 1'b1;
            end
            // only the CPU enable is gated, never in sleep
            cpuClkEn <= cpuTick && (state == ST_RUN);
        end
    end

    // divider on the system clock keeps domains aligned
    psc_doze_div #(
        .WIDTH(DIV_WIDTH)
    ) u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .slowActive(slowActive),
        .ratioCode(clock_divider_reg[`PSC_DOZE_HI:`PSC_DOZE_LO]),
        .cpuTick(cpuTick)
    );
endmodule

// >>> verif/psc_power_ctl_properties.sv
// Concurrent checks on the ports of the power saving control block
`timescale 1ns/1ns
module psc_power_ctl_properties (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    input wire clkEn,
    // Register bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    // Device state and outputs
    input wire low_volt_reg_fuse,
    input wire capacitorSinkOn,
    input wire wake_pin_irq_flag,
    input wire inSleep,
    input wire mainRegFull,
    input wire mainRegStandby,
    input wire lowVoltRegOn,
    input wire coreFromLowVolt,
    input wire cpuClkEn
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Request taken, and a completed write to the wake control word
    wire taken = wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
    wire wakeWr = clkEn && wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[1];
    // A status read is the only thing allowed to drop the flag
    wire statRd = wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == 4'hc;

    ack_pulse_a: assert property (clkEn && wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_timing_a: assert property (taken |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    sink_on_a: assert property (wakeWr && wb_dat_i[15] && wb_dat_i[8] && !wb_dat_i[13]
        |-> ##[1:2] capacitorSinkOn) else $error("sink not switched on");
    sink_off_a: assert property (wakeWr && !wb_dat_i[8] |-> ##[1:2] !capacitorSinkOn)
        else $error("sink not switched off");
    fuse_lowvolt_a: assert property (low_volt_reg_fuse && $past(low_volt_reg_fuse)
        |-> !lowVoltRegOn && !coreFromLowVolt) else $error("low volt regulator used with fuse");
    run_full_a: assert property (!inSleep && !$past(inSleep) && !$past(inSleep, 2)
        |-> mainRegFull && !coreFromLowVolt) else $error("run mode without full regulator");
    reg_excl_a: assert property (!(mainRegFull && mainRegStandby)
        && !(coreFromLowVolt && (mainRegFull || mainRegStandby)))
        else $error("regulator modes overlap");
    flag_keep_a: assert property (wake_pin_irq_flag && !statRd |=> wake_pin_irq_flag)
        else $error("wake flag lost without status read");
    sleep_cpu_a: assert property (inSleep && $past(inSleep) |-> !cpuClkEn)
        else $error("cpu tick during sleep");
endmodule

// >>> verif/psc_rc_cap.sv
// Behavioural model of the external capacitor on the wake sense pin
`timescale 1ns/1ns
module psc_rc_cap #(
    parameter DISCHARGE = 80
) (
    // Clock
    input wire sys_clk,
    // Charge drive and current sink
    input wire charge,
    input wire sinkOn,
    // Pin level seen by the input buffer
    output wire pinLevel
);
    integer level = 0;
    always @(posedge sys_clk) begin
        if (charge) begin
            level <= DISCHARGE;
        end else if (sinkOn && level > 0) begin
            level <= level - 1;
        end
    end
    // Ideal capacitor, no leakage: only the sink pulls it below threshold
    assign pinLevel = (level > DISCHARGE / 2);
endmodule

// >>> verif/psc_power_ctl_bench.sv
// Self-checking bench for the power saving control block
`timescale 1ns/1ns
module psc_power_ctl_bench;
    reg sys_clk = 0, rst_n = 0, clkEn = 1, cyc = 0, stb = 0, we = 0;
    reg [3:0] adr = 0, sel = 0;
    reg [31:0] wdat = 0, rd, d;
    reg sleepReq = 0, deepReq = 0, idleMode = 0, cpuIrq = 0, fuse = 0, charge = 0;
    wire [31:0] rdat;
    wire ack, pin, sinkOn, flag, inSleep, regFull, regStby, lvOn, coreLv, cpuClkEn, irqOut;
    integer num_errors = 0, n_checks = 0, cycCnt = 0, i, p, dF, dS, dL, d2;

    psc_power_ctl #(.DEEP_WAKE_CYCLES(20)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .clkEn(clkEn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sleepReq(sleepReq),
        .deepSleepReq(deepReq), .idleMode(idleMode), .cpuIrq(cpuIrq),
        .low_volt_reg_fuse(fuse), .wake_sense_pin(pin), .capacitorSinkOn(sinkOn),
        .wake_pin_irq_flag(flag), .inSleep(inSleep), .mainRegFull(regFull),
        .mainRegStandby(regStby), .lowVoltRegOn(lvOn), .coreFromLowVolt(coreLv),
        .cpuClkEn(cpuClkEn), .irqOut(irqOut));
    psc_rc_cap #(.DISCHARGE(80)) i_cap (.sys_clk(sys_clk), .charge(charge), .sinkOn(sinkOn),
        .pinLevel(pin));

    // 100 MHz clock; cycle ceiling cuts a hang short
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycCnt <= cycCnt + 1;
        if (cycCnt == 30000) begin
            num_errors = num_errors + 1;
            wrap_up;
        end
    end

    task wrap_up;
        begin
            if (num_errors == 0 && n_checks > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask

    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("MISMATCH %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // Writable bits of each control word; unmapped places read zero
    function [31:0] maskOf(input [3:0] a);
        case (a)
            4'h0: maskOf = 32'ha100;
            4'h4: maskOf = 32'h1100;
            4'h8: maskOf = 32'hf800;
            default: maskOf = 32'h0;
        endcase
    endfunction

    // Classic single cycle; holds everything until ack is sampled
    task wb(input w, input [3:0] a, input [31:0] dt);
        integer t;
        begin
            @(posedge sys_clk);
            cyc <= 1;
            stb <= 1;
            we <= w;
            adr <= a;
            sel <= 4'h3;
            wdat <= dt;
            t = 0;
            @(posedge sys_clk);
            while (ack !== 1'b1 && t < 50) begin
                t = t + 1;
                @(posedge sys_clk);
            end
            chk("bus answer", 1, t < 50);
            rd = rdat;
            cyc <= 0;
            stb <= 0;
        end
    endtask

    // Distance between cpu ticks, measured twice so a divider restart settles
    task gap;
        integer k;
        begin
            for (k = 0; k < 2; k = k + 1) begin
                p = 0;
                do begin
                    p = p + 1;
                    @(posedge sys_clk);
                end while (cpuClkEn !== 1'b1 && p < 300);
            end
        end
    endtask

    task kick;
        begin
            cpuIrq <= 1;
            @(posedge sys_clk);
            cpuIrq <= 0;
        end
    endtask

    // Charge, arm the wake unit and enter sleep in the chosen regulator mode
    task nap(input [15:0] wc, input [15:0] rc, input [15:0] msk, input [2:0] expReg);
        begin
            charge <= 1;
            repeat (2) @(posedge sys_clk);
            charge <= 0;
            wb(0, 4'hc, 0);
            wb(1, 4'hc, msk);
            wb(1, 4'h4, rc);
            wb(1, 4'h0, wc);
            sleepReq <= 1;
            for (p = 0; inSleep !== 1'b1 && p < 20; p = p + 1) @(posedge sys_clk);
            sleepReq <= 0;
            repeat (2) @(posedge sys_clk);
            chk("sleep regulators", expReg, {regFull, regStby, coreLv});
        end
    endtask

    // Wait for the pin wake, time the return to run, then clear status
    task rouse(input expIrq, output integer dur);
        begin
            for (p = 0; flag !== 1'b1 && p < 300; p = p + 1) @(posedge sys_clk);
            for (dur = 0; cpuClkEn !== 1'b1 && dur < 1000; dur = dur + 1) @(posedge sys_clk);
            chk("wake flag", 1, flag);
            chk("irq level", expIrq, irqOut);
            wb(0, 4'hc, 0);
            chk("status", 32'h3, rd[1:0]);
            repeat (3) @(posedge sys_clk);
            chk("flag after read", 0, {flag, irqOut});
        end
    endtask

    initial begin
        void'($urandom(83));
        repeat (8) @(posedge sys_clk);
        rst_n <= 1;
        // Reset values, then random writes against the writable masks
        for (i = 0; i < 4; i = i + 1) begin
            wb(0, (i == 3) ? 4'h2 : 4'(i * 4), 0);
            chk("reset word", 0, rd);
            d = $urandom;
            wb(1, (i == 3) ? 4'h2 : 4'(i * 4), d);
            wb(0, (i == 3) ? 4'h2 : 4'(i * 4), 0);
            chk("write mask", d & maskOf((i == 3) ? 4'h2 : 4'(i * 4)), rd);
        end
        wb(1, 4'h0, 0);
        // Every divide ratio
        for (i = 0; i < 8; i = i + 1) begin
            wb(1, 4'h8, 32'h0800 | (i << 12));
            gap;
            chk("tick gap", 1 << i, p);
            kick;
        end
        // Interrupt with and without return to full speed
        for (i = 0; i < 2; i = i + 1) begin
            wb(1, 4'h8, 0);
            wb(1, 4'h8, (i == 1) ? 32'hb800 : 32'h3800);
            kick;
            gap;
            chk("tick gap irq", (i == 1) ? 1 : 8, p);
        end
        wb(1, 4'h8, 0);
        gap;
        chk("full speed", 1, p);
        nap(16'h8100, 16'h0100, 16'h0300, 3'b100);
        rouse(1, dF);
        nap(16'h8100, 16'h0000, 16'h0000, 3'b010);
        rouse(0, dS);
        nap(16'h8100, 16'h1000, 16'h0300, 3'b001);
        rouse(1, dL);
        chk("wake order", 1, dF < dS && dS < dL);
        fuse <= 1;
        nap(16'h8100, 16'h1000, 16'h0300, 3'b010);
        chk("low volt on", 0, lvOn);
        rouse(1, d2);
        fuse <= 0;
        idleMode <= 1;
        nap(16'ha100, 16'h0100, 16'h0300, 3'b100);
        repeat (150) @(posedge sys_clk);
        chk("idle wake", 0, flag);
        idleMode <= 0;
        rouse(1, d2);
        // Deep sleep shuts both regulators until the request falls
        deepReq <= 1;
        for (p = 0; inSleep !== 1'b1 && p < 20; p = p + 1) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        chk("deep regulators", 0, {regFull, regStby, lvOn, coreLv});
        deepReq <= 0;
        for (d2 = 0; cpuClkEn !== 1'b1 && d2 < 1000; d2 = d2 + 1) @(posedge sys_clk);
        chk("deep wake", 1, d2 >= 20 && d2 < 1000);
        wrap_up;
    end
endmodule

bind psc_power_ctl psc_power_ctl_properties i_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .low_volt_reg_fuse(low_volt_reg_fuse), .capacitorSinkOn(capacitorSinkOn),
    .wake_pin_irq_flag(wake_pin_irq_flag), .inSleep(inSleep), .mainRegFull(mainRegFull),
    .mainRegStandby(mainRegStandby), .lowVoltRegOn(lowVoltRegOn),
    .coreFromLowVolt(coreFromLowVolt), .cpuClkEn(cpuClkEn));
